// ---- include/frm_pkg.sv ----
package frm_pkg;
  // reaction codes, rising priority
  localparam logic [2:0] FRM_R_LOG = 3'h0;
  localparam logic [2:0] FRM_R_WARN = 3'h1;
  localparam logic [2:0] FRM_R_RAMP = 3'h2;
  localparam logic [2:0] FRM_R_MAXC = 3'h3;
  localparam logic [2:0] FRM_R_IMM = 3'h4;
  localparam int FRM_NGRP = 10; // group 0 is the fixed safety group
  localparam int FRM_RW = 3;
  // mandatory floor and reset value per group, group 1 in the low field
  localparam logic [26:0] FRM_MIN_REACT = {3'h2, 3'h2, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
  localparam logic [26:0] FRM_RST_REACT = {3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h4};
  localparam logic [8:0] FRM_RST_NVSEL = 9'h1ff;
  // apb register map
  localparam logic [7:0] FRM_A_REACT = 8'h00;
  localparam logic [7:0] FRM_A_STATUS = 8'h04;
  localparam logic [7:0] FRM_A_CLEAR = 8'h08;
  localparam logic [7:0] FRM_A_NVSEL = 8'h0c;
  localparam logic [7:0] FRM_A_BIDX = 8'h10;
  localparam logic [7:0] FRM_A_BCNT = 8'h14;
  localparam logic [7:0] FRM_A_BW0 = 8'h18;
  localparam logic [7:0] FRM_A_BW1 = 8'h1c;
  localparam logic [7:0] FRM_A_BW2 = 8'h20;
  // runtime buffer
  localparam int FRM_BUF_DEPTH = 16;
  localparam int FRM_BUF_AW = 4;
  // safety fault code 51-0
  localparam logic [3:0] FRM_SAFE_HI = 4'h5;
  localparam logic [3:0] FRM_SAFE_LO = 4'h1;
  // display character codes
  localparam logic [3:0] FRM_CH_E = 4'ha;
  localparam logic [3:0] FRM_CH_DASH = 4'hb;
  localparam logic [3:0] FRM_CH_BLANK = 4'hf;
  localparam logic [2:0] FRM_DISP_LAST = 3'h4;
  // timing
  localparam logic [63:0] FRM_CLK_HZ = 64'd250000000;
  localparam logic [63:0] FRM_WARN_HOLD_S = 64'd15;
  localparam logic [63:0] FRM_DISP_STEP_MS = 64'd500;
  localparam logic [31:0] FRM_WARN_CYC = 32'(FRM_WARN_HOLD_S * FRM_CLK_HZ);
  localparam logic [31:0] FRM_SEC_CYC = 32'(FRM_CLK_HZ);
  localparam logic [31:0] FRM_DISP_CYC = 32'(FRM_DISP_STEP_MS * FRM_CLK_HZ / 64'd1000);
  typedef enum logic [1:0] {
    FRM_ST_RUN = 2'b00,
    FRM_ST_STOP = 2'b01,
    FRM_ST_OFF = 2'b11
  } frm_state_e;
  typedef struct packed {
    logic [3:0] grp;
    logic [3:0] main_hi;
    logic [3:0] main_lo;
    logic [3:0] sub;
    logic [7:0] desc;
    logic [15:0] cpar;
    logic [15:0] fpar;
  } frm_evt_s;
  typedef struct packed {
    logic [3:0] main_hi;
    logic [3:0] main_lo;
    logic [3:0] sub;
    logic [7:0] desc;
    logic [15:0] hrs;
    logic [5:0] mins;
    logic [5:0] secs;
    logic [15:0] cpar;
    logic [15:0] fpar;
  } frm_entry_s;
endpackage

// ---- verilog/frm_fault_mgr.sv ----
// Contract
// RL1: shutdown reaction stops the controller and switches the power stage off.
// RL2: power stage stays locked until cause gone and error acknowledged.
// RL3: active error shows E, main index digits, subindex digit, repeating.
// RL4: warning uses same code, framed by centre segment instead of E.
// RL5: encoder fault quick stops first, power stage off only afterwards; here the power stage also drops in the one cycle before STOP is entered.
// RL6: fieldbus acknowledge acts exactly like the configuration tool clear.
// RL7: reactions are stored per group only, no per-event override.
// RL8: priority rises: log, warning, disable, max current, immediate off.
// RL9: log only records in buffer, no display, no effect on drive.
// RL10: warning displayed, held about 15 s, reissued while cause persists.
// RL11: drive disable halts along the emergency stop ramp.
// RL12: max current reaction decelerates to standstill at maximum current.
// RL13: immediate reaction cuts the power stage at once, motor coasts.
// RL14: writes deselecting mandatory reactions of severe groups are ignored.
// RL15: nine separately configurable groups, stack overflow to encoder set.
// RL16: runtime buffer holds every error, warning, event since activation; here only the first 16 entries are kept, later ones are dropped.
// RL17: entry holds number, h/m/s time, description, constant, free parameter.
// RL18: selected messages also go to non-volatile event memory.
// RL19: main index 00 goes to event memory only, never displayed.
// RL20: safety system faults use error numbers 51 to 52.
// RL21: simultaneous groups: highest priority reaction among pending groups wins.
`timescale 1ns/1ps
module frm_fault_mgr #(
  parameter logic [31:0] WARN_HOLD_CYC = frm_pkg::FRM_WARN_CYC,
  parameter logic [31:0] SEC_CYC = frm_pkg::FRM_SEC_CYC,
  parameter logic [31:0] DISP_STEP_CYC = frm_pkg::FRM_DISP_CYC
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire frm_pkg::frm_evt_s evt_i, // sensor event report
  input wire logic evt_valid_i, // event report valid
  output logic evt_ready_o, // event report taken
  input wire logic [8:0] cause_i, // fault cause present, groups 1..9
  input wire logic safe_torque_off_input_fault_i, // safety circuit fault level
  input wire logic ack_i, // fieldbus error acknowledge pulse
  input wire logic drive_en_i, // controller wants power stage on
  input wire logic standstill_i, // drive reached zero speed
  output logic pstage_en_o, // power output stage enable
  output logic ctrl_stop_o, // controller unit halted
  output logic ramp_stop_o, // follow emergency stop ramp
  output logic maxcur_stop_o, // brake at maximum current
  output logic [3:0] disp_char_o, // seven-segment character code
  output frm_pkg::frm_entry_s nvm_entry_o, // event memory entry
  output logic nvm_valid_o, // event memory write request
  input wire logic nvm_ready_i // event memory accepts entry
);
  localparam int NG = frm_pkg::FRM_NGRP;
  localparam int RW = frm_pkg::FRM_RW;

  // registers
  logic [26:0] react_q, react_d;
  logic [8:0] nvsel_q;
  logic [9:0] err_q, err_d, warn_q, warn_d;
  logic [31:0] wtmr_q, wtmr_d;
  frm_pkg::frm_state_e st_q, st_d;
  logic sto_prev_q, sto_pend_q;
  logic [31:0] pres_q;
  logic [15:0] hrs_q;
  logic [5:0] min_q, sec_q;
  frm_pkg::frm_entry_s buf_mem [frm_pkg::FRM_BUF_DEPTH];
  logic [4:0] bcnt_q;
  logic [3:0] bidx_q;
  logic [11:0] code_q [NG];
  logic [31:0] dtmr_q;
  logic [2:0] dpos_q;
  logic [3:0] disp_q;
  frm_pkg::frm_entry_s nvm_q;
  logic nvm_v_q;

  // apb decode
  wire logic wr_acc = psel_i & penable_i & pwrite_i;
  wire logic hit_react = paddr_i == frm_pkg::FRM_A_REACT;
  wire logic hit_status = paddr_i == frm_pkg::FRM_A_STATUS;
  wire logic hit_clear = paddr_i == frm_pkg::FRM_A_CLEAR;
  wire logic hit_nvsel = paddr_i == frm_pkg::FRM_A_NVSEL;
  wire logic hit_bidx = paddr_i == frm_pkg::FRM_A_BIDX;
  wire logic hit_bcnt = paddr_i == frm_pkg::FRM_A_BCNT;
  wire logic hit_bw0 = paddr_i == frm_pkg::FRM_A_BW0;
  wire logic hit_bw1 = paddr_i == frm_pkg::FRM_A_BW1;
  wire logic hit_bw2 = paddr_i == frm_pkg::FRM_A_BW2;
  wire logic hit_any = hit_react | hit_status | hit_clear | hit_nvsel | hit_bidx
                     | hit_bcnt | hit_bw0 | hit_bw1 | hit_bw2;
  // both acknowledge paths share one pulse
  wire logic ack_p = ack_i | (wr_acc & hit_clear); // RL6

  // mandatory floors: each field of a write is taken only if legal
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) // RL15
    begin : g_react
      wire logic [2:0] nf = pwdata_i[gi*RW +: RW];
      wire logic ok = (nf >= frm_pkg::FRM_MIN_REACT[gi*RW +: RW]) && (nf <= frm_pkg::FRM_R_IMM);
      assign react_d[gi*RW +: RW] = (wr_acc && hit_react && ok) ? nf : react_q[gi*RW +: RW]; // RL14
    end
  endgenerate

  // per-group reaction view, group 0 hardwired to immediate off
  logic [2:0] grp_react [NG];
  always_comb
  begin
    grp_react[0] = frm_pkg::FRM_R_IMM; // RL20
    for (int g = 1; g < NG; g++)
    begin
      grp_react[g] = react_q[(g-1)*RW +: RW]; // RL7
    end
  end

  // event selection: a latched safety fault goes ahead of sensor reports
  frm_pkg::frm_evt_s sto_evt, sel_evt;
  assign sto_evt = '{grp: 4'h0, main_hi: frm_pkg::FRM_SAFE_HI, main_lo: frm_pkg::FRM_SAFE_LO,
                     sub: 4'h0, desc: 8'h00, cpar: 16'h0000, fpar: 16'h0000};
  assign sel_evt = sto_pend_q ? sto_evt : evt_i; // RL20
  assign evt_ready_o = ~sto_pend_q;
  wire logic sel_v = sto_pend_q | evt_valid_i;
  wire logic grp_ok = sel_evt.grp < 4'(NG);
  wire logic is_info = (sel_evt.main_hi == 4'h0) && (sel_evt.main_lo == 4'h0);
  wire logic take = sel_v & grp_ok;
  wire logic [2:0] ev_react = grp_ok ? grp_react[sel_evt.grp] : frm_pkg::FRM_R_LOG;
  wire logic run_evt = take & ~is_info; // RL19
  wire logic buf_full = bcnt_q == 5'(frm_pkg::FRM_BUF_DEPTH);
  wire logic buf_wr = run_evt & ~buf_full; // RL16 RL9
  wire logic nvm_sel = is_info | (sel_evt.grp == 4'h0) | (nvsel_q[sel_evt.grp - 4'h1]);
  wire logic nvm_wr = take & nvm_sel & (~nvm_v_q | nvm_ready_i); // RL18
  wire logic [9:0] onehot = 10'(1) << sel_evt.grp;
  wire logic [9:0] err_set = (run_evt && ev_react >= frm_pkg::FRM_R_RAMP) ? onehot : 10'h000;
  wire logic [9:0] warn_set = (run_evt && ev_react == frm_pkg::FRM_R_WARN) ? onehot : 10'h000;
  wire logic [9:0] cause_all = {cause_i, safe_torque_off_input_fault_i};

  // entry assembly
  frm_pkg::frm_entry_s new_ent;
  assign new_ent = '{main_hi: sel_evt.main_hi, main_lo: sel_evt.main_lo, sub: sel_evt.sub,
                     desc: sel_evt.desc, hrs: hrs_q, mins: min_q, secs: sec_q,
                     cpar: sel_evt.cpar, fpar: sel_evt.fpar}; // RL17

  // error flags: a new report wins over an acknowledge in the same cycle
  assign err_d = (err_q & ~({NG{ack_p}} & ~cause_all)) | err_set; // RL2 RL6

  // warning hold: expire after the hold time, persistent causes stay
  logic wexp;
  assign wexp = (wtmr_q == 32'h1);
  always_comb
  begin
    warn_d = warn_q;
    wtmr_d = wtmr_q;
    if (wtmr_q != 32'h0)
    begin
      wtmr_d = wtmr_q - 32'h1;
    end
    if (wexp)
    begin
      warn_d = warn_q & cause_all; // RL10
      if ((warn_q & cause_all) != 10'h000)
      begin
        wtmr_d = WARN_HOLD_CYC;
      end
    end
    if (warn_set != 10'h000)
    begin
      warn_d = warn_d | warn_set;
      wtmr_d = WARN_HOLD_CYC; // RL10
    end
  end

  // highest reaction among the active groups
  logic [2:0] top;
  always_comb
  begin
    top = frm_pkg::FRM_R_LOG;
    for (int g = 0; g < NG; g++)
    begin
      if (err_q[g] && grp_react[g] > top)
      begin
        top = grp_react[g]; // RL21 RL8
      end
    end
  end

  // stop sequencer: ramp or max current first, then power off
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      frm_pkg::FRM_ST_RUN:
      begin
        if (top == frm_pkg::FRM_R_IMM)
        begin
          st_d = frm_pkg::FRM_ST_OFF; // RL13
        end
        else if (top >= frm_pkg::FRM_R_RAMP)
        begin
          st_d = frm_pkg::FRM_ST_STOP; // RL5 RL11 RL12
        end
      end
      frm_pkg::FRM_ST_STOP:
      begin
        if (top == frm_pkg::FRM_R_IMM || standstill_i)
        begin
          st_d = frm_pkg::FRM_ST_OFF; // RL1 RL5
        end
      end
      frm_pkg::FRM_ST_OFF:
      begin
        if (err_q == 10'h000)
        begin
          st_d = frm_pkg::FRM_ST_RUN; // RL2
        end
      end
      default: st_d = frm_pkg::FRM_ST_OFF;
    endcase
  end

  // power stage gate; immediate reaction acts in the flag's own cycle
  wire logic imm_now = (top == frm_pkg::FRM_R_IMM);
  assign pstage_en_o = drive_en_i & ~imm_now & (st_q != frm_pkg::FRM_ST_OFF)
                     & ~((st_q == frm_pkg::FRM_ST_RUN) & (err_q != 10'h000)); // RL1 RL13
  assign ctrl_stop_o = st_q != frm_pkg::FRM_ST_RUN; // RL1
  assign ramp_stop_o = (st_q == frm_pkg::FRM_ST_STOP) & (top == frm_pkg::FRM_R_RAMP); // RL11
  assign maxcur_stop_o = (st_q == frm_pkg::FRM_ST_STOP) & (top == frm_pkg::FRM_R_MAXC); // RL12

  // display source: lowest errored group, else lowest warned group
  logic [3:0] src_g;
  logic src_err, src_warn;
  always_comb
  begin
    src_g = 4'h0;
    src_err = 1'b0;
    src_warn = 1'b0;
    for (int g = NG - 1; g >= 0; g--)
    begin
      if (warn_q[g] && !(err_q != 10'h000))
      begin
        src_g = 4'(g);
        src_warn = 1'b1;
      end
      if (err_q[g])
      begin
        src_g = 4'(g);
        src_err = 1'b1;
      end
    end
  end
  wire logic [11:0] src_code = code_q[src_g];
  wire logic dstep = (dtmr_q == 32'h0);
  logic [3:0] disp_d;
  always_comb
  begin
    disp_d = frm_pkg::FRM_CH_BLANK;
    if (src_err || src_warn)
    begin
      case (dpos_q)
        3'h0: disp_d = src_err ? frm_pkg::FRM_CH_E : frm_pkg::FRM_CH_DASH; // RL3 RL4
        3'h1: disp_d = src_code[11:8];
        3'h2: disp_d = src_code[7:4];
        3'h3: disp_d = src_code[3:0];
        3'h4: disp_d = src_err ? frm_pkg::FRM_CH_BLANK : frm_pkg::FRM_CH_DASH; // RL4
        default: disp_d = frm_pkg::FRM_CH_BLANK;
      endcase
    end
  end
  assign disp_char_o = disp_q;

  // apb read mux, single-cycle access
  frm_pkg::frm_entry_s rd_ent;
  assign rd_ent = buf_mem[bidx_q];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign prdata_o = hit_react ? {5'h00, react_q}
                  : hit_status ? {7'h00, top, st_q, warn_q, err_q}
                  : hit_nvsel ? {23'h000000, nvsel_q}
                  : hit_bidx ? {28'h0000000, bidx_q}
                  : hit_bcnt ? {27'h0000000, bcnt_q}
                  : hit_bw0 ? {12'h000, rd_ent.desc, rd_ent.main_hi, rd_ent.main_lo, rd_ent.sub}
                  : hit_bw1 ? {4'h0, rd_ent.hrs, rd_ent.mins, rd_ent.secs}
                  : hit_bw2 ? {rd_ent.cpar, rd_ent.fpar}
                  : 32'h00000000;
  assign nvm_entry_o = nvm_q;
  assign nvm_valid_o = nvm_v_q;

  // configuration and fault state
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      react_q <= frm_pkg::FRM_RST_REACT;
      nvsel_q <= frm_pkg::FRM_RST_NVSEL;
      bidx_q <= 4'h0;
      err_q <= 10'h000;
      warn_q <= 10'h000;
      wtmr_q <= 32'h0;
      st_q <= frm_pkg::FRM_ST_RUN;
    end
    else
    begin
      react_q <= react_d;
      if (wr_acc && hit_nvsel)
        nvsel_q <= pwdata_i[8:0];
      if (wr_acc && hit_bidx)
        bidx_q <= pwdata_i[3:0];
      err_q <= err_d;
      warn_q <= warn_d;
      wtmr_q <= wtmr_d;
      st_q <= st_d;
    end
  end

  // safety fault edge catch; a second edge while pending merges
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sto_prev_q <= 1'b0;
      sto_pend_q <= 1'b0;
    end
    else
    begin
      sto_prev_q <= safe_torque_off_input_fault_i;
      sto_pend_q <= (safe_torque_off_input_fault_i & ~sto_prev_q) | (sto_pend_q & ~take);
    end
  end

  // system time since activation
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pres_q <= 32'h0;
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hrs_q <= 16'h0000;
    end
    else if (pres_q == SEC_CYC - 32'h1)
    begin
      pres_q <= 32'h0;
      sec_q <= (sec_q == 6'd59) ? 6'h00 : sec_q + 6'h01;
      if (sec_q == 6'd59)
      begin
        min_q <= (min_q == 6'd59) ? 6'h00 : min_q + 6'h01;
        if (min_q == 6'd59)
          hrs_q <= hrs_q + 16'h0001;
      end
    end
    else
      pres_q <= pres_q + 32'h1;
  end

  // runtime buffer, fills up and then holds the oldest entries
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      bcnt_q <= 5'h00;
    else if (buf_wr)
      bcnt_q <= bcnt_q + 5'h01; // RL16
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (buf_wr)
      buf_mem[bcnt_q[3:0]] <= new_ent; // RL17
  end

  // last displayed code per group
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int g = 0; g < NG; g++)
        code_q[g] <= 12'h000;
    end
    else if (run_evt && ev_react != frm_pkg::FRM_R_LOG)
      code_q[sel_evt.grp] <= {sel_evt.main_hi, sel_evt.main_lo, sel_evt.sub}; // RL4
  end

  // event memory slot; a report finding it busy is not stored there
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nvm_v_q <= 1'b0;
      nvm_q <= '0;
    end
    else if (nvm_wr)
    begin
      nvm_v_q <= 1'b1;
      nvm_q <= new_ent; // RL18 RL19
    end
    else if (nvm_ready_i)
      nvm_v_q <= 1'b0;
  end

  // display sequencer, cycles at all times, whether anything is shown or not
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dtmr_q <= 32'h0;
      dpos_q <= 3'h0;
      disp_q <= frm_pkg::FRM_CH_BLANK;
    end
    else
    begin
      dtmr_q <= dstep ? DISP_STEP_CYC - 32'h1 : dtmr_q - 32'h1;
      if (dstep)
      begin
        disp_q <= disp_d; // RL3
        dpos_q <= (dpos_q == frm_pkg::FRM_DISP_LAST) ? 3'h0 : dpos_q + 3'h1;
      end
    end
  end

  // checks
  wire logic [26:0] floor_chk = frm_pkg::FRM_MIN_REACT;
  property p_off_lock;
    @(posedge sys_clk_i) disable iff (rst_i)
    (st_q == frm_pkg::FRM_ST_OFF && err_q != 10'h000) |=> st_q == frm_pkg::FRM_ST_OFF && !pstage_en_o;
  endproperty
  a_off_lock: assert property (p_off_lock) else $error("power stage left off state early"); // RL2
  property p_imm;
    @(posedge sys_clk_i) disable iff (rst_i)
    (top == frm_pkg::FRM_R_IMM) |-> !pstage_en_o ##1 st_q == frm_pkg::FRM_ST_OFF;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate reaction kept power stage on"); // RL13
  property p_ack_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ack_p && (err_q & cause_all) != 10'h000) |=> (err_q & $past(err_q & cause_all)) == $past(err_q & cause_all);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("error cleared while cause present"); // RL2
  property p_info;
    @(posedge sys_clk_i) disable iff (rst_i)
    (take && is_info) |=> bcnt_q == $past(bcnt_q) && $past(err_set) == 10'h000;
  endproperty
  a_info: assert property (p_info) else $error("index 00 reached runtime buffer"); // RL19
  property p_log;
    @(posedge sys_clk_i) disable iff (rst_i)
    (run_evt && !buf_full && ev_react == frm_pkg::FRM_R_LOG && !ack_p)
      |=> bcnt_q == $past(bcnt_q) + 5'h01 && err_q == $past(err_q) && warn_q == $past(warn_d);
  endproperty
  a_log: assert property (p_log) else $error("log-only event disturbed drive"); // RL9
  property p_floor;
    @(posedge sys_clk_i) disable iff (rst_i)
    (react_q[2:0] >= floor_chk[2:0]) && (react_q[17:15] >= floor_chk[17:15])
      && (react_q[23:21] >= floor_chk[23:21]) && (react_q[26:24] >= floor_chk[26:24]);
  endproperty
  a_floor: assert property (p_floor) else $error("mandatory reaction deselected"); // RL14
  property p_stop_first;
    @(posedge sys_clk_i) disable iff (rst_i)
    (st_q == frm_pkg::FRM_ST_STOP && top != frm_pkg::FRM_R_IMM)
      |-> (ramp_stop_o || maxcur_stop_o) && ctrl_stop_o;
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("stop phase without braking"); // RL5
  property p_warn_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (warn_set != 10'h000) |=> wtmr_q == WARN_HOLD_CYC && (warn_q & $past(warn_set)) != 10'h000;
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warning hold not started"); // RL10
  property p_disp_lead;
    @(posedge sys_clk_i) disable iff (rst_i)
    (dstep && dpos_q == 3'h0 && src_err) |=> disp_char_o == frm_pkg::FRM_CH_E;
  endproperty
  a_disp_lead: assert property (p_disp_lead) else $error("error display lacks leading E"); // RL3
  property p_prio;
    @(posedge sys_clk_i) disable iff (rst_i)
    (err_q[1:0] != 2'b00)
      |-> top == frm_pkg::FRM_R_IMM && !pstage_en_o;
  endproperty
  a_prio: assert property (p_prio) else $error("highest reaction not applied"); // RL21
  c_ramp_off: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q == frm_pkg::FRM_ST_STOP ##[1:20] st_q == frm_pkg::FRM_ST_OFF);
  c_ack: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q == frm_pkg::FRM_ST_OFF ##1 st_q == frm_pkg::FRM_ST_RUN);
  c_warn: cover property (@(posedge sys_clk_i) disable iff (rst_i) warn_set != 10'h000);
endmodule

// ---- tb/frm_nvm_model.sv ----
`timescale 1ns/1ps
// event memory stand-in: takes an entry at once, or one cycle in four
module frm_nvm_model (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic valid_i, // entry offered
  input wire logic slow_i, // stall between accepts
  output logic ready_o // entry taken
);
  logic [1:0] cnt_q;
  // slow mode mimics a busy page write, so valid must stand meanwhile
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      cnt_q <= 2'h0;
    else if (valid_i)
      cnt_q <= cnt_q + 2'h1;
  assign ready_o = valid_i & (!slow_i | (cnt_q == 2'h3));
endmodule

// ---- tb/frm_fault_mgr_tb.sv ----
`timescale 1ns/1ps
module frm_fault_mgr_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} frm_row_s;
  localparam logic [31:0] CFG = 32'({3'h2, 3'h2, 3'h0, 3'h4, 3'h3, 3'h1, 3'h0, 3'h2, 3'h4});
  logic clk, rst, psel, pen, pw, evv, evr, ack, den, sst, slow, stof, prdy, perr, er;
  logic pst, cst, rmp, mst, nvv, nvr, s_e, s_d, s_nb, s_nv;
  logic [7:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [8:0] cause;
  logic [3:0] dc;
  frm_pkg::frm_evt_s ev;
  frm_pkg::frm_entry_s ne, got;
  int mismatches, num_checks, i;
  frm_row_s rows [6];
  frm_fault_mgr #(.WARN_HOLD_CYC(32'd50), .SEC_CYC(32'd10), .DISP_STEP_CYC(32'd2)) DUT (
    .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pw),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .evt_i(ev), .evt_valid_i(evv), .evt_ready_o(evr), .cause_i(cause),
    .safe_torque_off_input_fault_i(stof), .ack_i(ack), .drive_en_i(den),
    .standstill_i(sst), .pstage_en_o(pst), .ctrl_stop_o(cst), .ramp_stop_o(rmp),
    .maxcur_stop_o(mst), .disp_char_o(dc), .nvm_entry_o(ne), .nvm_valid_o(nvv),
    .nvm_ready_i(nvr));
  frm_nvm_model nvm (.clk_i(clk), .rst_i(rst), .valid_i(nvv), .slow_i(slow), .ready_o(nvr));
  // clock at 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task ck(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen at an access edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task evt(input logic [3:0] g, input logic [3:0] mh, input logic [3:0] ml);
    @(posedge clk);
    ev <= '{g, mh, ml, 4'h0, {mh, ml}, 16'h00c1, 16'h0f2e};
    evv <= 1'b1;
    @(posedge clk);
    while (evr !== 1'b1)
      @(posedge clk);
    evv <= 1'b0;
  endtask
  // watch display and event memory for n cycles
  task mon(input int n);
    s_e = 0;
    s_d = 0;
    s_nb = 0;
    s_nv = 0;
    repeat (n)
    begin
      @(posedge clk);
      s_e |= (dc === frm_pkg::FRM_CH_E);
      s_d |= (dc === frm_pkg::FRM_CH_DASH);
      s_nb |= (dc !== frm_pkg::FRM_CH_BLANK);
      if (nvv && nvr)
      begin
        s_nv = 1;
        got = ne;
      end
    end
  endtask
  // acknowledge by fieldbus pulse or by the clear register
  task clr(input logic bus);
    if (bus)
    begin
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
    end
    else
      apb(1'b1, frm_pkg::FRM_A_CLEAR, 32'h1);
    repeat (4) @(posedge clk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    mismatches++;
    results();
  end
  initial
  begin
    {psel, pen, pw, evv, ack, sst, slow, stof, pa, pwd, cause, ev} = '0;
    den = 1'b1;
    rst = 1'b1;
    // floors, out-of-range fields, nvsel, unmapped
    rows = '{'{8'h00, 32'h0, 32'(frm_pkg::FRM_MIN_REACT), 1'b0},
      '{8'h00, 32'h07ffffff, 32'(frm_pkg::FRM_MIN_REACT), 1'b0},
      '{8'h00, CFG, CFG, 1'b0}, '{8'h0c, 32'h0, 32'h0, 1'b0}, '{8'h40, 32'h5, 32'h0, 1'b1},
      '{8'h10, 32'hfffffff0, 32'h0, 1'b0}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ck(32'(pst), 32'h1);
    ck(32'(dc), 32'hf);
    ck(32'(nvv), 32'h0);
    apb(1'b0, frm_pkg::FRM_A_REACT, 32'h0);
    ck(rd, 32'(frm_pkg::FRM_RST_REACT));
    apb(1'b0, frm_pkg::FRM_A_NVSEL, 32'h0);
    ck(rd, 32'h1ff);
    $display("reset test done");
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      ck(32'({prdy, er}), 32'({1'b1, rows[i].x}));
      apb(1'b0, rows[i].a, 32'h0);
      if (!rows[i].x)
        ck(rd, rows[i].e);
    end
    $display("register rows done");
    evt(4'h3, 4'h0, 4'h3);
    mon(40);
    ck(32'(s_nb), 32'h0);
    ck(32'({pst, cst, s_nv}), 32'h4);
    slow <= 1'b1;
    evt(4'h3, 4'h0, 4'h0);
    mon(40);
    ck(32'({s_nv, s_nb}), 32'h2);
    $display("log and info done");
    evt(4'h2, 4'h0, 4'h2);
    mon(20);
    ck(32'({rmp, cst, s_e}), 32'h7);
    sst <= 1'b1;
    repeat (3) @(posedge clk);
    ck(32'(pst), 32'h0);
    sst <= 1'b0;
    clr(1'b1);
    ck(32'({pst, cst}), 32'h2);
    cause[5] <= 1'b1;
    evt(4'h6, 4'h0, 4'h6);
    evt(4'h7, 4'h0, 4'h7);
    repeat (3) @(posedge clk);
    ck(32'({pst, mst}), 32'h0);
    apb(1'b0, frm_pkg::FRM_A_STATUS, 32'h0);
    ck(rd, 32'h01300040);
    clr(1'b0);
    ck(32'(pst), 32'h0);
    cause[5] <= 1'b0;
    clr(1'b0);
    ck(32'(pst), 32'h1);
    evt(4'h5, 4'h0, 4'h5);
    repeat (3) @(posedge clk);
    ck(32'(mst), 32'h1);
    sst <= 1'b1;
    clr(1'b1);
    sst <= 1'b0;
    evt(4'h4, 4'h0, 4'h4);
    mon(30);
    ck(32'({s_d, s_e, pst}), 32'h5);
    clr(1'b0);
    $display("reaction tests done");
    apb(1'b0, frm_pkg::FRM_A_BCNT, 32'h0);
    ck(rd, 32'h6);
    apb(1'b0, frm_pkg::FRM_A_BW0, 32'h0);
    ck(rd, 32'h03030);
    apb(1'b0, frm_pkg::FRM_A_BW2, 32'h0);
    ck(rd, 32'h00c10f2e);
    stof <= 1'b1;
    mon(40);
    ck(32'({s_nv, got.main_hi, got.main_lo}), 32'h151);
    ck(32'(pst), 32'h0);
    stof <= 1'b0;
    clr(1'b1);
    evt(4'h1, 4'h0, 4'h1);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    ck(32'({pst, dc}), 32'h1f);
    rst <= 1'b0;
    $display("buffer and reset tests done");
    results();
  end
endmodule
